// ==== logic/ssd_pipe_ctrl.sv ====
// Purpose: Fetch fold, dispatch, unit tracking and in-order completion control
// Assumes: Fetch offers one instruction per clock; datapath moves operands
// Notes: Exceptions and traces redirect fetch with a one-cycle pulse
`timescale 1ns/10ps
module ssd_pipe_ctrl (
  input wire logic core_clk_i, // 20 MHz core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire ssd_pkg::ssd_instr_t fetch_i, // Fetched instruction
  output logic fetch_rdy_o, // Queue takes one
  input wire logic [ssd_pkg::N_UNITS-1:0] unit_hold_i, // Unit needs more cycles
  input wire logic [ssd_pkg::N_UNITS-1:0] unit_exc_i, // Last stage faults
  input wire logic [ssd_pkg::N_UNITS-1:0][ssd_pkg::VEC_W-1:0] unit_vec_i, // Vectors
  input wire logic single_step_trace_enable_i, // Trace every retire except isync
  input wire logic branch_trace_enable_i, // Trace retired branches
  output ssd_pkg::ssd_issue_t [ssd_pkg::DISP_SLOTS-1:0] issue_o, // Latched by units
  output ssd_pkg::ssd_fin_t [ssd_pkg::N_UNITS-1:0] unit_fin_o, // Rename writes
  output ssd_pkg::ssd_commit_t [ssd_pkg::RET_MAX-1:0] commit_o, // Architected copy
  output logic redirect_o, // Refetch pulse
  output logic [ssd_pkg::VEC_W-1:0] redirect_vec_o // Refetch vector
);
  ssd_pkg::ssd_instr_t iq_q [ssd_pkg::IQ_DEPTH];
  logic [2:0] iq_cnt_q;
  logic [2:0] iq_cnt_d;
  logic push;
  logic fold;
  logic [ssd_pkg::CQ_DEPTH-1:0] cq_v_q;
  logic [ssd_pkg::CQ_DEPTH-1:0] cq_done_q;
  logic [ssd_pkg::CQ_DEPTH-1:0] cq_exc_q;
  logic [ssd_pkg::VEC_W-1:0] cq_vec_q [ssd_pkg::CQ_DEPTH];
  ssd_pkg::ssd_instr_t cq_ins_q [ssd_pkg::CQ_DEPTH];
  logic [ssd_pkg::TAG_W-1:0] head_q;
  logic [ssd_pkg::TAG_W-1:0] tail_q;
  logic [2:0] cq_cnt_q;
  logic [2:0] cq_free;
  logic [ssd_pkg::SB_N-1:0] sb_busy_q;
  logic [ssd_pkg::TAG_W-1:0] sb_tag_q [ssd_pkg::SB_N];
  logic [ssd_pkg::N_UNITS-1:0] u_rdy;
  logic [ssd_pkg::N_UNITS-1:0] u_iss;
  logic [ssd_pkg::TAG_W-1:0] u_tag [ssd_pkg::N_UNITS];
  logic [ssd_pkg::N_UNITS-1:0] used;
  logic [ssd_pkg::DISP_SLOTS-1:0] d_go;
  logic [ssd_pkg::TAG_W-1:0] d_tag [ssd_pkg::DISP_SLOTS];
  ssd_pkg::ssd_issue_t [ssd_pkg::DISP_SLOTS-1:0] issue_d;
  logic [1:0] n_disp;
  int nd;
  int unum;
  logic ok;
  logic go;
  logic busy;
  logic fresh;
  logic [ssd_pkg::TAG_W-1:0] stag;
  logic [ssd_pkg::REG_W:0] sidx;
  logic [ssd_pkg::RET_MAX-1:0] ret_go;
  logic [ssd_pkg::TAG_W-1:0] ret_idx [ssd_pkg::RET_MAX];
  ssd_pkg::ssd_commit_t [ssd_pkg::RET_MAX-1:0] commit_d;
  logic [1:0] n_ret;
  logic flush_req;
  logic ret_trc;
  logic stop;
  logic trc;
  logic [ssd_pkg::VEC_W-1:0] flush_vec;
  logic [ssd_pkg::TAG_W-1:0] ri;

  // ============================================================
  // Fetch side: fold plain branches, drop wrong-path words
  assign fold = fetch_i.cls == ssd_pkg::CLS_BR && !fetch_i.wr_ctr && !fetch_i.wr_lr;
  assign push = fetch_i.vld && fetch_rdy_o && !redirect_o && !flush_req && !fold;
  assign iq_cnt_d = flush_req ? 3'h0 : iq_cnt_q - 3'(n_disp) + 3'(push);
  assign cq_free = 3'(ssd_pkg::CQ_DEPTH) - cq_cnt_q;

  // Instruction queue with shift-down on dispatch
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      iq_cnt_q <= 3'h0;
      for (int k = 0; k < ssd_pkg::IQ_DEPTH; k++) begin
        iq_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < ssd_pkg::IQ_DEPTH; k++) begin
        if (k + n_disp < ssd_pkg::IQ_DEPTH) begin
          iq_q[k] <= iq_q[k+n_disp];
        end
      end
      if (push) begin
        iq_q[iq_cnt_q - 3'(n_disp)] <= fetch_i;
      end
      iq_cnt_q <= iq_cnt_d;
    end
  end

  // ============================================================
  // Dispatch selection and operand tagging
  always_comb begin
    used = '0;
    u_iss = '0;
    d_go = '0;
    issue_d = '0;
    nd = 0;
    go = 1'b1;
    for (int u = 0; u < ssd_pkg::N_UNITS; u++) begin
      u_tag[u] = '0;
    end
    for (int s = 0; s < ssd_pkg::DISP_SLOTS; s++) begin
      d_tag[s] = ssd_pkg::ptr_add(tail_q, nd);
      case (iq_q[s].cls)
        ssd_pkg::CLS_INT: begin
          unum = (u_rdy[ssd_pkg::U_INT0] && !used[ssd_pkg::U_INT0]) ?
                 ssd_pkg::U_INT0 : ssd_pkg::U_INT1;
        end
        ssd_pkg::CLS_FP: unum = ssd_pkg::U_FP;
        ssd_pkg::CLS_LS: unum = ssd_pkg::U_LS;
        ssd_pkg::CLS_BR: unum = ssd_pkg::U_BR;
        default: unum = ssd_pkg::U_SYS;
      endcase
      ok = go && (s < iq_cnt_q) && !flush_req && (nd < cq_free) &&
           u_rdy[unum] && !used[unum] &&
           (iq_q[s].cls == ssd_pkg::CLS_BR || s < ssd_pkg::NB_DISP_MAX);
      sidx = {iq_q[s].float_register_file, iq_q[s].src};
      busy = sb_busy_q[sidx];
      stag = sb_tag_q[sidx];
      fresh = 1'b0;
      for (int p = 0; p < s; p++) begin
        if (d_go[p] && iq_q[p].wr_dst && {iq_q[p].float_register_file, iq_q[p].dst} == sidx) begin
          busy = 1'b1;
          stag = d_tag[p];
          fresh = 1'b1;
        end
      end
      issue_d[s].vld = ok;
      issue_d[s].unit = 3'(unum);
      issue_d[s].tag = d_tag[s];
      issue_d[s].src_ren = busy;
      issue_d[s].src_tag = stag;
      issue_d[s].src_rdy = !busy || (!fresh && cq_done_q[stag]);
      issue_d[s].ins = iq_q[s];
      if (ok) begin
        d_go[s] = 1'b1;
        used[unum] = 1'b1;
        u_iss[unum] = 1'b1;
        u_tag[unum] = d_tag[s];
        nd = nd + 1;
      end else begin
        go = 1'b0;
      end
    end
    n_disp = 2'(nd);
  end

  // ============================================================
  // Execution units
  generate
    for (genvar u = 0; u < ssd_pkg::N_UNITS; u++) begin : g_unit
      ssd_exec_unit #(
        .DEPTH(ssd_pkg::UNIT_LAT[u]),
        .HALT_ON_EXC(u != ssd_pkg::U_FP)
      ) u_exec (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(flush_req),
        .iss_vld_i(u_iss[u]),
        .iss_tag_i(u_tag[u]),
        .hold_i(unit_hold_i[u]),
        .exc_i(unit_exc_i[u]),
        .vec_i(unit_vec_i[u]),
        .rdy_o(u_rdy[u]),
        .fin_o(unit_fin_o[u])
      );
    end
  endgenerate

  // ============================================================
  // Completion: in-order retire from the two oldest entries
  always_comb begin
    n_ret = 2'h0;
    ret_go = '0;
    commit_d = '0;
    flush_req = 1'b0;
    ret_trc = 1'b0;
    flush_vec = ssd_pkg::TRACE_VEC;
    stop = 1'b0;
    for (int r = 0; r < ssd_pkg::RET_MAX; r++) begin
      ri = ssd_pkg::ptr_add(head_q, r);
      ret_idx[r] = ri;
      trc = !cq_ins_q[ri].isync && (single_step_trace_enable_i ||
            (cq_ins_q[ri].cls == ssd_pkg::CLS_BR && branch_trace_enable_i));
      if (!stop && cq_v_q[ri] && cq_done_q[ri]) begin
        if (cq_exc_q[ri]) begin
          if (r == 0) begin
            flush_req = 1'b1;
            flush_vec = cq_vec_q[ri];
          end
          stop = 1'b1;
        end else begin
          ret_go[r] = 1'b1;
          n_ret = n_ret + 2'h1;
          commit_d[r].vld = 1'b1;
          commit_d[r].wr_gpr = cq_ins_q[ri].wr_dst && !cq_ins_q[ri].float_register_file;
          commit_d[r].wr_fpr = cq_ins_q[ri].wr_dst && cq_ins_q[ri].float_register_file;
          commit_d[r].wr_ctr = cq_ins_q[ri].wr_ctr;
          commit_d[r].wr_lr = cq_ins_q[ri].wr_lr;
          commit_d[r].dst = cq_ins_q[ri].dst;
          commit_d[r].tag = ri;
          if (trc) begin
            flush_req = 1'b1;
            ret_trc = 1'b1;
            flush_vec = ssd_pkg::TRACE_VEC;
            stop = 1'b1;
          end
        end
      end else begin
        stop = 1'b1;
      end
    end
  end

  // Completion queue control; finish sets done, flush cancels all
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cq_v_q <= '0;
      cq_done_q <= '0;
      cq_exc_q <= '0;
      head_q <= '0;
      tail_q <= '0;
      cq_cnt_q <= 3'h0;
    end else if (flush_req) begin
      cq_v_q <= '0;
      head_q <= '0;
      tail_q <= '0;
      cq_cnt_q <= 3'h0;
    end else begin
      for (int u = 0; u < ssd_pkg::N_UNITS; u++) begin
        if (unit_fin_o[u].vld) begin
          cq_done_q[unit_fin_o[u].tag] <= 1'b1;
          cq_exc_q[unit_fin_o[u].tag] <= unit_fin_o[u].exc;
        end
      end
      for (int r = 0; r < ssd_pkg::RET_MAX; r++) begin
        if (ret_go[r]) begin
          cq_v_q[ret_idx[r]] <= 1'b0;
        end
      end
      for (int s = 0; s < ssd_pkg::DISP_SLOTS; s++) begin
        if (d_go[s]) begin
          cq_v_q[d_tag[s]] <= 1'b1;
          cq_done_q[d_tag[s]] <= 1'b0;
          cq_exc_q[d_tag[s]] <= 1'b0;
        end
      end
      head_q <= ssd_pkg::ptr_add(head_q, n_ret);
      tail_q <= ssd_pkg::ptr_add(tail_q, n_disp);
      cq_cnt_q <= cq_cnt_q + 3'(n_disp) - 3'(n_ret);
    end
  end

  // Completion queue payload
  always_ff @(posedge core_clk_i) begin
    for (int u = 0; u < ssd_pkg::N_UNITS; u++) begin
      if (unit_fin_o[u].vld) begin
        cq_vec_q[unit_fin_o[u].tag] <= unit_fin_o[u].vec;
      end
    end
    for (int s = 0; s < ssd_pkg::DISP_SLOTS; s++) begin
      if (d_go[s]) begin
        cq_ins_q[d_tag[s]] <= iq_q[s];
      end
    end
  end

  // Rename scoreboard; a new producer wins over a retiring one
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sb_busy_q <= '0;
      for (int i = 0; i < ssd_pkg::SB_N; i++) begin
        sb_tag_q[i] <= '0;
      end
    end else if (flush_req) begin
      sb_busy_q <= '0;
    end else begin
      for (int r = 0; r < ssd_pkg::RET_MAX; r++) begin
        if (ret_go[r] && cq_ins_q[ret_idx[r]].wr_dst &&
            sb_tag_q[{cq_ins_q[ret_idx[r]].float_register_file, cq_ins_q[ret_idx[r]].dst}] == ret_idx[r]) begin
          sb_busy_q[{cq_ins_q[ret_idx[r]].float_register_file, cq_ins_q[ret_idx[r]].dst}] <= 1'b0;
        end
      end
      for (int s = 0; s < ssd_pkg::DISP_SLOTS; s++) begin
        if (d_go[s] && iq_q[s].wr_dst) begin
          sb_busy_q[{iq_q[s].float_register_file, iq_q[s].dst}] <= 1'b1;
          sb_tag_q[{iq_q[s].float_register_file, iq_q[s].dst}] <= d_tag[s];
        end
      end
    end
  end

  // ============================================================
  // Registered outputs
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      issue_o <= '0;
      commit_o <= '0;
      redirect_o <= 1'b0;
      redirect_vec_o <= '0;
      fetch_rdy_o <= 1'b0;
    end else begin
      issue_o <= issue_d;
      commit_o <= commit_d;
      redirect_o <= flush_req;
      if (flush_req) begin
        redirect_vec_o <= flush_vec;
      end
      fetch_rdy_o <= iq_cnt_d < 3'(ssd_pkg::IQ_DEPTH);
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_exc_head;
    cq_v_q[head_q] && cq_done_q[head_q] && cq_exc_q[head_q];
  endsequence
  sequence s_drained;
    redirect_o && cq_cnt_q == 3'h0 && iq_cnt_q == 3'h0 && !issue_o[0].vld;
  endsequence

  property p_exc_head;
    (flush_req && !ret_trc) |-> s_exc_head;
  endproperty
  a_exc_head: assert property (p_exc_head) else $error("Exception raised early");

  property p_flush;
    flush_req |=> s_drained;
  endproperty
  a_flush: assert property (p_flush) else $error("Flush left work behind");

  property p_trace;
    ret_trc |=> redirect_o && redirect_vec_o == ssd_pkg::TRACE_VEC;
  endproperty
  a_trace: assert property (p_trace) else $error("Trace vector wrong");

  property p_slot2_br;
    issue_o[2].vld |-> issue_o[2].ins.cls == ssd_pkg::CLS_BR && issue_o[1].vld;
  endproperty
  a_slot2_br: assert property (p_slot2_br) else $error("Non-branch from third slot");

  property p_one_br;
    $onehot0({issue_o[0].vld && issue_o[0].ins.cls == ssd_pkg::CLS_BR,
              issue_o[1].vld && issue_o[1].ins.cls == ssd_pkg::CLS_BR,
              issue_o[2].vld && issue_o[2].ins.cls == ssd_pkg::CLS_BR});
  endproperty
  a_one_br: assert property (p_one_br) else $error("Two branches in one cycle");

  property p_cq_full;
    (cq_cnt_q == 3'(ssd_pkg::CQ_DEPTH)) |=> !issue_o[0].vld;
  endproperty
  a_cq_full: assert property (p_cq_full) else $error("Dispatch into full queue");

  property p_cq_track;
    !flush_req |=> cq_cnt_q == $past(cq_cnt_q) + 3'($past(n_disp)) - 3'($past(n_ret));
  endproperty
  a_cq_track: assert property (p_cq_track) else $error("Completion count off");

  property p_fold;
    (fetch_i.vld && fetch_rdy_o && fold && !redirect_o && !flush_req) |=>
      iq_cnt_q == $past(iq_cnt_q) - 3'($past(n_disp));
  endproperty
  a_fold: assert property (p_fold) else $error("Folded branch was queued");

  property p_ret_pair;
    commit_o[1].vld |-> commit_o[0].vld &&
      commit_o[1].tag == ssd_pkg::ptr_add(commit_o[0].tag, 1);
  endproperty
  a_ret_pair: assert property (p_ret_pair) else $error("Retire out of order");

  property p_opnd;
    (issue_o[0].vld && !issue_o[0].src_ren) |-> issue_o[0].src_rdy;
  endproperty
  a_opnd: assert property (p_opnd) else $error("File operand not ready");
endmodule

// ==== shared/ssd_pkg.sv ====
// Purpose: Shared constants and carriers for the dispatch/completion pipeline control
// Assumes: Single 20 MHz core clock, no software-visible registers
// Notes: Rename register tag equals the completion queue slot index
// ============================================================
// Behaviour
// - Every instruction not folded at fetch flows fetch, dispatch, execute, then completes, in order.
// - Fetch drops branches writing neither count register nor link register.
// - Dispatch reads ready operands, else sends the producing rename tag.
// - The chosen unit latches instruction and operands at end of dispatch.
// - Non-branches dispatch from the lowest two queue positions, two per clock.
// - Each dispatched instruction takes one of six completion queue entries.
// - One branch may join two others, three dispatched per clock at most.
// - A finished unit writes its rename register and tells completion.
// - A faulting unit reports it; all but float unit then halt.
// - A reported exception is raised only once its instruction is oldest.
// - Float unit pipelines three stages, three instructions in flight.
// - Load/store unit has two stages: address/translate, then cache access.
// - Retire copies rename results into register files, count and link.
// - Only the lowest two completion entries retire, two per clock.
// - An exception cancels younger work, drops renames, refetches at vector.
// - Six units: two integer, float, branch, load/store, system register.
// - Trace vectors to 00D00 on single step or traced branch; sync never.
package ssd_pkg;
  // ============================================================
  // Sizes
  localparam int IQ_DEPTH = 6;
  localparam int CQ_DEPTH = 6;
  localparam int TAG_W = 3;
  localparam int REG_W = 5;
  localparam int VEC_W = 20;
  localparam int SB_N = 64;
  localparam int N_UNITS = 6;
  localparam int DISP_SLOTS = 3;
  localparam int NB_DISP_MAX = 2;
  localparam int RET_MAX = 2;
  localparam logic [TAG_W-1:0] TAG_LAST = 3'h5;
  localparam logic [VEC_W-1:0] TRACE_VEC = 20'h00d00;
  // ============================================================
  // Execution units and their depths
  localparam int U_INT0 = 0;
  localparam int U_INT1 = 1;
  localparam int U_FP = 2;
  localparam int U_BR = 3;
  localparam int U_LS = 4;
  localparam int U_SYS = 5;
  localparam int UNIT_LAT [N_UNITS] = '{1, 1, 3, 1, 2, 1};
  // ============================================================
  // Carriers
  typedef enum logic [2:0] {CLS_INT, CLS_FP, CLS_LS, CLS_SYS, CLS_BR} ssd_cls_t;
  typedef struct packed {
    logic vld;
    ssd_cls_t cls;
    logic float_register_file;
    logic [REG_W-1:0] src;
    logic [REG_W-1:0] dst;
    logic wr_dst;
    logic wr_ctr;
    logic wr_lr;
    logic isync;
  } ssd_instr_t;
  typedef struct packed {
    logic vld;
    logic [2:0] unit;
    logic [TAG_W-1:0] tag;
    logic src_rdy;
    logic src_ren;
    logic [TAG_W-1:0] src_tag;
    ssd_instr_t ins;
  } ssd_issue_t;
  typedef struct packed {
    logic vld;
    logic [TAG_W-1:0] tag;
    logic exc;
    logic [VEC_W-1:0] vec;
  } ssd_fin_t;
  typedef struct packed {
    logic vld;
    logic wr_gpr;
    logic wr_fpr;
    logic wr_ctr;
    logic wr_lr;
    logic [REG_W-1:0] dst;
    logic [TAG_W-1:0] tag;
  } ssd_commit_t;
  // Ring pointer advance by n, wrapping at the last slot
  function automatic logic [TAG_W-1:0] ptr_add(input logic [TAG_W-1:0] p, input int n);
    logic [TAG_W-1:0] t;
    t = p;
    for (int i = 0; i < 3; i++) begin
      if (i < n) begin
        t = (t == TAG_LAST) ? '0 : t + 3'h1;
      end
    end
    return t;
  endfunction
endpackage

// ==== logic/ssd_exec_unit.sv ====
// Purpose: Stage tracker of one execution unit
// Assumes: hold_i freezes all occupied stages while the datapath needs more cycles
// Notes: Finish is registered, one cycle after the last stage advances
`timescale 1ns/10ps
module ssd_exec_unit #(
  parameter int DEPTH = 1,
  parameter bit HALT_ON_EXC = 1'b1
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic flush_i, // Cancel everything in flight
  input wire logic iss_vld_i, // Dispatch into this unit
  input wire logic [ssd_pkg::TAG_W-1:0] iss_tag_i, // Rename tag
  input wire logic hold_i, // Stall stages
  input wire logic exc_i, // Last stage faults
  input wire logic [ssd_pkg::VEC_W-1:0] vec_i, // Fault vector
  output logic rdy_o, // Can take one
  output ssd_pkg::ssd_fin_t fin_o // Rename write and finish
);
  logic [DEPTH-1:0] v_q;
  logic [DEPTH-1:0][ssd_pkg::TAG_W-1:0] t_q;
  logic halt_q;
  logic adv;

  // Advance unless stalled or halted on a fault
  assign adv = !hold_i && !halt_q;
  assign rdy_o = !halt_q && (!v_q[0] || adv);

  // ============================================================
  // Stage shift
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      v_q <= '0;
      t_q <= '0;
    end else if (flush_i) begin
      v_q <= '0;
    end else if (adv) begin
      for (int k = DEPTH - 1; k > 0; k--) begin
        v_q[k] <= v_q[k-1];
        t_q[k] <= t_q[k-1];
      end
      v_q[0] <= iss_vld_i;
      t_q[0] <= iss_tag_i;
    end else if (iss_vld_i && !v_q[0]) begin
      v_q[0] <= 1'b1;
      t_q[0] <= iss_tag_i;
    end
  end

  // Finish report and fault halt
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fin_o <= '0;
      halt_q <= 1'b0;
    end else if (flush_i) begin
      fin_o <= '0;
      halt_q <= 1'b0;
    end else begin
      fin_o.vld <= v_q[DEPTH-1] && adv;
      fin_o.tag <= t_q[DEPTH-1];
      fin_o.exc <= exc_i;
      fin_o.vec <= vec_i;
      if (HALT_ON_EXC && v_q[DEPTH-1] && adv && exc_i) begin
        halt_q <= 1'b1;
      end
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_fin_cause;
    fin_o.vld |-> $past(v_q[DEPTH-1]) && $past(!hold_i) && $past(!flush_i);
  endproperty
  a_fin_cause: assert property (p_fin_cause) else $error("Finish without last stage");

  property p_halt;
    (fin_o.vld && fin_o.exc && HALT_ON_EXC) |-> !rdy_o;
  endproperty
  a_halt: assert property (p_halt) else $error("Unit runs on after fault");

  generate
    if (DEPTH > 1) begin : g_shift
      property p_shift;
        (adv && !flush_i) |=> v_q[DEPTH-1:1] == $past(v_q[DEPTH-2:0]);
      endproperty
      a_shift: assert property (p_shift) else $error("Stage did not advance");
    end
  endgenerate
endmodule

// ==== dv/ssd_fetch_model.sv ====
// Purpose: Fetch side model feeding the pipeline control
// Assumes: Bench loads prog before pulsing start_i
// Notes: Stops at a refetch; vectors lie outside the loaded program
`timescale 1ns/10ps
module ssd_fetch_model (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic start_i, // Begin program
  input wire logic [4:0] len_i, // Program length
  input wire logic gap_i, // Withhold a new offer
  input wire logic rdy_i, // Queue takes one
  input wire logic redir_i, // Refetch pulse
  output ssd_pkg::ssd_instr_t fetch_o // Offered word
);
  ssd_pkg::ssd_instr_t prog [32];
  int pc;
  int n;
  logic take;
  // ==========
  // Offer, hold until taken; idle bus shows inverted junk
  always @(posedge core_clk_i or negedge rst_b_i) begin
    take = fetch_o.vld && rdy_i && !redir_i;
    if (!rst_b_i) begin
      pc = 0;
      n = 0;
      fetch_o <= '0;
    end else begin
      if (start_i) begin
        pc = 0;
        n = len_i;
      end else if (redir_i) begin
        n = 0;
      end else if (take) begin
        pc++;
      end
      if (fetch_o.vld && !take && !redir_i) begin
        fetch_o <= fetch_o;
      end else if (pc < n && !gap_i) begin
        fetch_o <= prog[pc];
      end else begin
        fetch_o <= ssd_pkg::ssd_instr_t'({1'b0, ~fetch_o[$bits(fetch_o)-2:0]});
      end
    end
  end
endmodule

// ==== dv/ssd_pipe_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the pipeline control
// Assumes: Fetch model drives fetch side; bench drives unit inputs
// Notes: Commits and refetches are checked against queued notes
`timescale 1ns/10ps
module ssd_pipe_ctrl_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic start = 1'b0;
  logic gap = 1'b0;
  logic rnd = 1'b0;
  logic step_en = 1'b0;
  logic br_en = 1'b0;
  logic [4:0] len = '0;
  logic [5:0] hold = '0;
  logic [5:0] exc = '0;
  logic [5:0][19:0] vec = '0;
  logic fetch_rdy_o;
  logic redirect_o;
  logic [19:0] redirect_vec_o;
  ssd_pkg::ssd_instr_t fetch_i;
  ssd_pkg::ssd_issue_t [2:0] issue_o;
  ssd_pkg::ssd_fin_t [5:0] fin;
  ssd_pkg::ssd_commit_t [1:0] commit_o;
  logic [31:0] seed = 32'h5b;
  logic [31:0] r;
  logic [8:0] e;
  logic [2:0] ctag = 3'h0;
  logic [8:0] exp_c [$];
  logic [19:0] exp_r [$];
  int nprog = 0;
  int err_count = 0;
  int comparisons = 0;
  // ==========
  // Clock and instances
  always #25 core_clk_i = ~core_clk_i;
  ssd_fetch_model fm (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .start_i(start),
    .len_i(len), .gap_i(gap), .rdy_i(fetch_rdy_o), .redir_i(redirect_o), .fetch_o(fetch_i));
  ssd_pipe_ctrl dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .fetch_i(fetch_i),
    .fetch_rdy_o(fetch_rdy_o), .unit_hold_i(hold), .unit_exc_i(exc), .unit_vec_i(vec),
    .single_step_trace_enable_i(step_en), .branch_trace_enable_i(br_en), .issue_o(issue_o),
    .unit_fin_o(fin), .commit_o(commit_o), .redirect_o(redirect_o),
    .redirect_vec_o(redirect_vec_o));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random unit stalls and fetch gaps
  always @(posedge core_clk_i) begin
    r = xs();
    hold <= rnd ? (r[5:0] & r[11:6] & r[17:12]) : 6'h00;
    gap <= rnd & r[20];
  end
  task automatic chk_commit(input logic [11:0] ex, input logic [11:0] sn);
    comparisons++;
    if (sn !== ex) begin
      err_count++;
      $display("wrong value commit expected %h seen %h", ex, sn);
    end
  endtask
  task automatic chk_vec(input logic [19:0] ex, input logic [19:0] sn);
    comparisons++;
    if (sn !== ex) begin
      err_count++;
      $display("wrong value refetch vector expected %h seen %h", ex, sn);
    end
  endtask
  // Watch results, oldest note first
  always @(negedge core_clk_i) begin
    for (int s = 0; s < 2; s++) begin
      if (rst_b_i && commit_o[s].vld === 1'b1) begin
        e = exp_c.size() ? exp_c.pop_front() : 'x;
        chk_commit({e, ctag}, {commit_o[s].wr_gpr, commit_o[s].wr_fpr,
          commit_o[s].wr_ctr, commit_o[s].wr_lr,
          commit_o[s].dst, commit_o[s].tag});
        // Completion slots are handed out in ring order
        ctag = (ctag == ssd_pkg::TAG_LAST) ? 3'h0 : ctag + 3'h1;
      end
    end
    if (rst_b_i && redirect_o === 1'b1) begin
      chk_vec(exp_r.size() ? exp_r.pop_front() : 'x, redirect_vec_o);
      ctag = 3'h0;
    end
  end
  // Load one word and note its commit
  task automatic add(input ssd_pkg::ssd_cls_t c, input logic fp, input logic ctr,
    input logic lr, input logic sy, input logic keep);
    ssd_pkg::ssd_instr_t i;
    logic [31:0] v;
    v = xs();
    i = '0;
    i.vld = 1'b1;
    i.cls = c;
    i.float_register_file = fp;
    i.src = v[4:0];
    i.wr_dst = (c != ssd_pkg::CLS_BR) && (c != ssd_pkg::CLS_SYS);
    i.dst = i.wr_dst ? v[9:5] : 5'h00;
    i.wr_ctr = ctr;
    i.wr_lr = lr;
    i.isync = sy;
    fm.prog[nprog] = i;
    nprog++;
    if (keep) exp_c.push_back({i.wr_dst & ~fp, i.wr_dst & fp, ctr, lr, i.dst});
  endtask
  task automatic run(input string name);
    len <= 5'(nprog);
    start <= 1'b1;
    @(posedge core_clk_i);
    start <= 1'b0;
    for (int k = 0; k < 800 && (exp_c.size() + exp_r.size()) > 0; k++) @(posedge core_clk_i);
    repeat (12) @(posedge core_clk_i);
    if (exp_c.size() + exp_r.size() > 0) begin
      err_count++;
      $display("wrong value pending results expected 0 seen %0d", exp_c.size() + exp_r.size());
      exp_c.delete();
      exp_r.delete();
    end
    nprog = 0;
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    for (int m = 0; m < 2; m++) begin
      rnd <= m[0];
      for (int k = 0; k < 3; k++) begin
        add(ssd_pkg::CLS_INT, 0, 0, 0, 0, 1);
        add(ssd_pkg::CLS_FP, 1, 0, 0, 0, 1);
        add(ssd_pkg::CLS_LS, 0, 0, 0, 0, 1);
        add(ssd_pkg::CLS_SYS, 0, 0, 0, 0, 1);
        add(ssd_pkg::CLS_BR, 0, 1, 0, 0, 1);
        add(ssd_pkg::CLS_BR, 0, 0, 0, 0, 0);
        add(ssd_pkg::CLS_BR, 0, 0, 1, 0, 1);
      end
      run("mixed stream");
    end
    rnd <= 1'b0;
    // Faulting load/store halts; faulting float unit keeps running
    for (int f = 0; f < 2; f++) begin
      r = xs();
      vec <= {6{r[19:0]}};
      exc <= f ? 6'h04 : 6'h10;
      add(ssd_pkg::CLS_INT, 0, 0, 0, 0, 1);
      add(f ? ssd_pkg::CLS_FP : ssd_pkg::CLS_LS, f[0], 0, 0, 0, 0);
      add(ssd_pkg::CLS_INT, 0, 0, 0, 0, 0);
      add(ssd_pkg::CLS_FP, 1, 0, 0, 0, 0);
      exp_r.push_back(r[19:0]);
      run(f ? "float fault" : "load store fault");
    end
    exc <= 6'h00;
    step_en <= 1'b1;
    add(ssd_pkg::CLS_SYS, 0, 0, 0, 1, 1);
    add(ssd_pkg::CLS_INT, 0, 0, 0, 0, 1);
    add(ssd_pkg::CLS_INT, 0, 0, 0, 0, 0);
    exp_r.push_back(ssd_pkg::TRACE_VEC);
    run("single step trace");
    step_en <= 1'b0;
    br_en <= 1'b1;
    add(ssd_pkg::CLS_BR, 0, 0, 0, 0, 0);
    add(ssd_pkg::CLS_INT, 0, 0, 0, 0, 1);
    add(ssd_pkg::CLS_BR, 0, 0, 1, 0, 1);
    add(ssd_pkg::CLS_INT, 0, 0, 0, 0, 0);
    exp_r.push_back(ssd_pkg::TRACE_VEC);
    run("branch trace");
    br_en <= 1'b0;
    close_out();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    $display("wrong value watchdog expected finish seen timeout");
    close_out();
  end
endmodule
